// ===== logic/dam_pkg.sv
// Shared constants and types for the dual alarm event monitor
package dam_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W  = 7;
  localparam int DATA_W  = 16;
  localparam int SMP_W   = 14;
  localparam int ACC_W   = 24;
  localparam int CNT_W   = 8;
  localparam int SEL_W   = 4;
  localparam int NUM_SRC = 11;
  localparam int NUM_CH  = 2;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFF_THR1   = 7'h26;
  localparam logic [ADDR_W-1:0] OFF_THR2   = 7'h28;
  localparam logic [ADDR_W-1:0] OFF_CNT1   = 7'h2A;
  localparam logic [ADDR_W-1:0] OFF_CNT2   = 7'h2C;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 7'h2E;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 7'h3C;

  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] THR_MASK  = 16'hBFFF;
  localparam logic [DATA_W-1:0] CNT_MASK  = 16'h00FF;
  localparam logic [DATA_W-1:0] CTRL_MASK = 16'hFFD7;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int THR_DIR_BIT     = 15;
  localparam int THR_RSV_BIT     = 14;
  localparam int CTRL_SRC2_LSB   = 12;
  localparam int CTRL_SRC1_LSB   = 8;
  localparam int CTRL_SLOPE2_BIT = 7;
  localparam int CTRL_SLOPE1_BIT = 6;
  localparam int CTRL_FILT_BIT   = 4;
  localparam int CTRL_OUT_EN_BIT = 2;
  localparam int CTRL_POL_BIT    = 1;
  localparam int CTRL_LINE_BIT   = 0;
  localparam int STAT_ALM1_BIT   = 8;
  localparam int STAT_ALM2_BIT   = 9;

  // ----------------------------------------
  // Source codes
  // ----------------------------------------
  localparam logic [SEL_W-1:0] SRC_DISABLE = 4'h0;
  localparam logic [SEL_W-1:0] SRC_LAST    = 4'hB;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [NUM_SRC-1:0][SMP_W-1:0] dam_src_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dam_reg_req_t;

endpackage

// ===== logic/dam_alarm_monitor.sv
// Dual alarm event monitor: registers, comparators, status and pin drive
`timescale 1ns/1ps
`default_nettype none

module dam_alarm_monitor (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_reset,
  input  wire dam_pkg::dam_reg_req_t     i_reg_req,
  output logic [dam_pkg::DATA_W-1:0]     o_reg_rdata,
  input  wire logic                      i_sample_valid,
  input  wire dam_pkg::dam_src_t         i_src_raw,
  input  wire dam_pkg::dam_src_t         i_src_filt,
  output logic [dam_pkg::NUM_CH-1:0]     o_alarm_active,
  output logic                           o_gp_line_zero,
  output logic                           o_gp_line_zero_oe_n,
  output logic                           o_gp_line_one,
  output logic                           o_gp_line_one_oe_n
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic signed [dam_pkg::ACC_W-1:0] dam_sext(input logic [dam_pkg::SMP_W-1:0] x);
    dam_sext = $signed({{(dam_pkg::ACC_W-dam_pkg::SMP_W){x[dam_pkg::SMP_W-1]}}, x});
  endfunction

  function automatic logic dam_cmp(input logic signed [dam_pkg::ACC_W-1:0] v,
                                   input logic [dam_pkg::DATA_W-1:0]       thr);
    logic signed [dam_pkg::ACC_W-1:0] m;
    m       = dam_sext(thr[dam_pkg::SMP_W-1:0]);
    dam_cmp = thr[dam_pkg::THR_DIR_BIT] ? (v > m) : (v < m);
  endfunction

  function automatic logic signed [dam_pkg::ACC_W-1:0] dam_avg(input logic signed [dam_pkg::ACC_W-1:0] s,
                                                               input logic [dam_pkg::CNT_W-1:0]        n);
    logic signed [dam_pkg::ACC_W-1:0] d;
    d       = $signed({{(dam_pkg::ACC_W-dam_pkg::CNT_W){1'b0}}, n});
    dam_avg = s / d;
  endfunction

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [dam_pkg::DATA_W-1:0] thr_reg [dam_pkg::NUM_CH];
  logic [dam_pkg::DATA_W-1:0] cnt_reg [dam_pkg::NUM_CH];
  logic [dam_pkg::DATA_W-1:0] ctrl_reg;
  logic [dam_pkg::NUM_CH-1:0] status_reg;
  logic [dam_pkg::NUM_CH-1:0] status_next;
  logic [dam_pkg::NUM_CH-1:0] alarm_reg;
  logic [dam_pkg::DATA_W-1:0] rd_mux;

  wire wr_thr1 = i_reg_req.wr && (i_reg_req.addr == dam_pkg::OFF_THR1);
  wire wr_thr2 = i_reg_req.wr && (i_reg_req.addr == dam_pkg::OFF_THR2);
  wire wr_cnt1 = i_reg_req.wr && (i_reg_req.addr == dam_pkg::OFF_CNT1);
  wire wr_cnt2 = i_reg_req.wr && (i_reg_req.addr == dam_pkg::OFF_CNT2);
  wire wr_ctrl = i_reg_req.wr && (i_reg_req.addr == dam_pkg::OFF_CTRL);
  wire rd_stat = i_reg_req.rd && (i_reg_req.addr == dam_pkg::OFF_STATUS);

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      thr_reg[0] <= dam_pkg::REG_RESET;
      thr_reg[1] <= dam_pkg::REG_RESET;
      cnt_reg[0] <= dam_pkg::REG_RESET;
      cnt_reg[1] <= dam_pkg::REG_RESET;
      ctrl_reg   <= dam_pkg::REG_RESET;
    end else begin
      if (wr_thr1) thr_reg[0] <= i_reg_req.wdata & dam_pkg::THR_MASK;
      if (wr_thr2) thr_reg[1] <= i_reg_req.wdata & dam_pkg::THR_MASK;
      if (wr_cnt1) cnt_reg[0] <= i_reg_req.wdata & dam_pkg::CNT_MASK;
      if (wr_cnt2) cnt_reg[1] <= i_reg_req.wdata & dam_pkg::CNT_MASK;
      if (wr_ctrl) ctrl_reg   <= i_reg_req.wdata & dam_pkg::CTRL_MASK;
    end
  end

  // Set wins over a read clear
  assign status_next = (rd_stat ? '0 : status_reg) | alarm_reg;

  always_comb begin
    rd_mux = '0;
    case (i_reg_req.addr)
      dam_pkg::OFF_THR1:   rd_mux = thr_reg[0];
      dam_pkg::OFF_THR2:   rd_mux = thr_reg[1];
      dam_pkg::OFF_CNT1:   rd_mux = cnt_reg[0];
      dam_pkg::OFF_CNT2:   rd_mux = cnt_reg[1];
      dam_pkg::OFF_CTRL:   rd_mux = ctrl_reg;
      dam_pkg::OFF_STATUS: begin
        rd_mux[dam_pkg::STAT_ALM1_BIT] = status_reg[0];
        rd_mux[dam_pkg::STAT_ALM2_BIT] = status_reg[1];
      end
      default:             rd_mux = '0;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      status_reg  <= '0;
      o_reg_rdata <= '0;
    end else begin
      status_reg <= status_next;
      if (i_reg_req.rd) o_reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // Alarm channels
  // ----------------------------------------
  wire use_filt = ctrl_reg[dam_pkg::CTRL_FILT_BIT];
  wire dam_pkg::dam_src_t src_word = use_filt ? i_src_filt : i_src_raw;

  logic [dam_pkg::SEL_W-1:0]        src_sel  [dam_pkg::NUM_CH];
  logic                             slope_compare_enable [dam_pkg::NUM_CH];
  logic                             ch_on    [dam_pkg::NUM_CH];
  logic [dam_pkg::SMP_W-1:0]        sample_w [dam_pkg::NUM_CH];
  logic signed [dam_pkg::ACC_W-1:0] avg_w    [dam_pkg::NUM_CH];
  logic                             done_w   [dam_pkg::NUM_CH];
  logic                             hit_w    [dam_pkg::NUM_CH];
  logic [dam_pkg::CNT_W-1:0]        n_eff    [dam_pkg::NUM_CH];
  logic [dam_pkg::CNT_W-1:0]        nd_reg   [dam_pkg::NUM_CH];
  logic                             prev_ok_reg [dam_pkg::NUM_CH];

  for (genvar ch = 0; ch < dam_pkg::NUM_CH; ch++) begin : g_ch
    logic [dam_pkg::SMP_W-1:0]        prev_reg;
    logic signed [dam_pkg::ACC_W-1:0] acc_reg;
    logic signed [dam_pkg::ACC_W-1:0] delta_w;
    logic signed [dam_pkg::ACC_W-1:0] sum_w;
    logic [dam_pkg::CNT_W:0]          nd_inc;
    logic                             step;
    wire                              cnt_wr = (ch == 0) ? wr_cnt1 : wr_cnt2;

    assign src_sel[ch] = (ch == 0) ? ctrl_reg[dam_pkg::CTRL_SRC1_LSB +: dam_pkg::SEL_W]
                                   : ctrl_reg[dam_pkg::CTRL_SRC2_LSB +: dam_pkg::SEL_W];
    assign slope_compare_enable[ch] = (ch == 0) ? ctrl_reg[dam_pkg::CTRL_SLOPE1_BIT]
                                                : ctrl_reg[dam_pkg::CTRL_SLOPE2_BIT];
    assign ch_on[ch] = (src_sel[ch] != dam_pkg::SRC_DISABLE) && (src_sel[ch] <= dam_pkg::SRC_LAST);
    assign sample_w[ch] = ch_on[ch] ? src_word[src_sel[ch] - 4'h1] : '0;
    assign n_eff[ch] = (cnt_reg[ch][dam_pkg::CNT_W-1:0] == '0) ? 8'h01 : cnt_reg[ch][dam_pkg::CNT_W-1:0];
    assign delta_w = dam_sext(sample_w[ch]) - dam_sext(prev_reg);
    assign sum_w = acc_reg + delta_w;
    assign nd_inc = {1'b0, nd_reg[ch]} + 9'h001;
    assign step = i_sample_valid && ch_on[ch] && slope_compare_enable[ch] && prev_ok_reg[ch];
    assign done_w[ch] = step && (nd_inc >= {1'b0, n_eff[ch]});
    assign avg_w[ch] = dam_avg(sum_w, n_eff[ch]);
    assign hit_w[ch] = slope_compare_enable[ch] ? dam_cmp(avg_w[ch], thr_reg[ch])
                                                : dam_cmp(dam_sext(sample_w[ch]), thr_reg[ch]);

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
        prev_reg        <= '0;
        prev_ok_reg[ch] <= 1'b0;
        acc_reg         <= '0;
        nd_reg[ch]      <= '0;
      end else if (!ch_on[ch] || !slope_compare_enable[ch] || cnt_wr) begin
        prev_ok_reg[ch] <= 1'b0;
        acc_reg         <= '0;
        nd_reg[ch]      <= '0;
      end else if (i_sample_valid) begin
        prev_reg        <= sample_w[ch];
        prev_ok_reg[ch] <= 1'b1;
        acc_reg         <= (!prev_ok_reg[ch] || done_w[ch]) ? '0 : sum_w;
        nd_reg[ch]      <= (!prev_ok_reg[ch] || done_w[ch]) ? '0 : nd_inc[dam_pkg::CNT_W-1:0];
      end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
        alarm_reg[ch] <= 1'b0;
      end else if (!ch_on[ch]) begin
        alarm_reg[ch] <= 1'b0;
      end else if (slope_compare_enable[ch] ? done_w[ch] : i_sample_valid) begin
        alarm_reg[ch] <= hit_w[ch];
      end
    end
  end

  assign o_alarm_active = alarm_reg;

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  wire out_en   = ctrl_reg[dam_pkg::CTRL_OUT_EN_BIT];
  wire out_pol  = ctrl_reg[dam_pkg::CTRL_POL_BIT];
  wire out_line = ctrl_reg[dam_pkg::CTRL_LINE_BIT];
  wire any_alm  = |alarm_reg;
  wire pin_lvl  = any_alm ? out_pol : ~out_pol;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_gp_line_zero      <= 1'b0;
      o_gp_line_zero_oe_n <= 1'b1;
      o_gp_line_one       <= 1'b0;
      o_gp_line_one_oe_n  <= 1'b1;
    end else begin
      o_gp_line_zero      <= (out_en && !out_line) ? pin_lvl : 1'b0;
      o_gp_line_zero_oe_n <= !(out_en && !out_line);
      o_gp_line_one       <= (out_en && out_line) ? pin_lvl : 1'b0;
      o_gp_line_one_oe_n  <= !(out_en && out_line);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  AST_STAT_SET: assert property (alarm_reg[0] |=> status_reg[0])
    else $error("alarm 1 not latched in status");
  AST_STAT_HOLD: assert property (status_reg[1] && !rd_stat |=> status_reg[1])
    else $error("alarm 2 status lost without read");
  AST_STAT_CLR: assert property (rd_stat && alarm_reg == '0 |=> status_reg == '0)
    else $error("status not cleared by read");
  AST_RD_STAT: assert property (rd_stat |=> o_reg_rdata[dam_pkg::STAT_ALM2_BIT -: 2] == $past(status_reg))
    else $error("status read data wrong");
  AST_STATIC_GT: assert property (i_sample_valid && ch_on[0] && !slope_compare_enable[0]
      && thr_reg[0][dam_pkg::THR_DIR_BIT] && dam_sext(sample_w[0]) > dam_sext(thr_reg[0][13:0])
      ##1 ch_on[0] |-> alarm_reg[0])
    else $error("greater-than alarm missed");
  AST_STATIC_LT: assert property (i_sample_valid && ch_on[1] && !slope_compare_enable[1]
      && !thr_reg[1][dam_pkg::THR_DIR_BIT] && dam_sext(sample_w[1]) >= dam_sext(thr_reg[1][13:0])
      ##1 ch_on[1] |-> !alarm_reg[1])
    else $error("less-than alarm falsely raised");
  AST_DISABLED: assert property (!ch_on[0] |=> !alarm_reg[0])
    else $error("disabled channel raised alarm");
  AST_THR_RSV: assert property (!thr_reg[0][dam_pkg::THR_RSV_BIT] && !thr_reg[1][dam_pkg::THR_RSV_BIT])
    else $error("threshold unused bit set");
  AST_WIN_BOUND: assert property (nd_reg[0] < n_eff[0] || !prev_ok_reg[0])
    else $error("delta count exceeded window");
  AST_SLOPE_RES: assert property (done_w[1] ##1 ch_on[1] |-> alarm_reg[1] == $past(hit_w[1]))
    else $error("slope result not applied");
  AST_PIN_ON: assert property (out_en && !out_line && any_alm |=> !o_gp_line_zero_oe_n
      && o_gp_line_zero == $past(out_pol))
    else $error("line zero not at asserted level");
  AST_PIN_OFF: assert property (!out_en |=> o_gp_line_zero_oe_n && o_gp_line_one_oe_n)
    else $error("pin driven while disabled");

  // ----------------------------------------
  // Register assertions
  // ----------------------------------------
  AST_WR_THR1: assert property (wr_thr1 |=> thr_reg[0] == ($past(i_reg_req.wdata) & dam_pkg::THR_MASK))
    else $error("threshold 1 write wrong");
  AST_WR_THR2: assert property (wr_thr2 |=> thr_reg[1] == ($past(i_reg_req.wdata) & dam_pkg::THR_MASK))
    else $error("threshold 2 write wrong");
  AST_WR_CNT1: assert property (wr_cnt1 |=> cnt_reg[0] == ($past(i_reg_req.wdata) & dam_pkg::CNT_MASK))
    else $error("sample count 1 write wrong");
  AST_WR_CNT2: assert property (wr_cnt2 |=> cnt_reg[1] == ($past(i_reg_req.wdata) & dam_pkg::CNT_MASK))
    else $error("sample count 2 write wrong");
  AST_WR_CTRL: assert property (wr_ctrl |=> ctrl_reg == ($past(i_reg_req.wdata) & dam_pkg::CTRL_MASK))
    else $error("control write wrong");
  AST_CNT_RSV: assert property (cnt_reg[0][dam_pkg::DATA_W-1:dam_pkg::CNT_W] == '0
      && cnt_reg[1][dam_pkg::DATA_W-1:dam_pkg::CNT_W] == '0)
    else $error("sample count unused bits set");
  AST_CTRL_HOLD: assert property (!wr_ctrl |=> $stable(ctrl_reg))
    else $error("control changed without write");
  AST_THR_HOLD: assert property (!wr_thr1 |=> $stable(thr_reg[0]))
    else $error("threshold 1 changed without write");
  AST_STAT_SET2: assert property (alarm_reg[1] |=> status_reg[1])
    else $error("alarm 2 not latched in status");
  AST_STAT_HOLD1: assert property (status_reg[0] && !rd_stat |=> status_reg[0])
    else $error("alarm 1 status lost without read");
  AST_STAT_QUIET: assert property (!status_reg[0] && !alarm_reg[0] |=> !status_reg[0])
    else $error("alarm 1 status set without alarm");
  AST_RD_HOLD: assert property (!i_reg_req.rd |=> $stable(o_reg_rdata))
    else $error("read data changed without read");
  AST_RD_CTRL: assert property (i_reg_req.rd && i_reg_req.addr == dam_pkg::OFF_CTRL
      |=> o_reg_rdata == $past(ctrl_reg))
    else $error("control read data wrong");
  AST_RD_STAT_RSV: assert property (rd_stat |=> o_reg_rdata[dam_pkg::STAT_ALM1_BIT-1:0] == '0)
    else $error("status low bits not zero");

  // ----------------------------------------
  // Channel assertions
  // ----------------------------------------
  AST_STATIC_GT2: assert property (i_sample_valid && ch_on[1] && !slope_compare_enable[1]
      && thr_reg[1][dam_pkg::THR_DIR_BIT] && dam_sext(sample_w[1]) > dam_sext(thr_reg[1][13:0])
      ##1 ch_on[1] |-> alarm_reg[1])
    else $error("alarm 2 greater-than missed");
  AST_STATIC_LT1: assert property (i_sample_valid && ch_on[0] && !slope_compare_enable[0]
      && !thr_reg[0][dam_pkg::THR_DIR_BIT] && dam_sext(sample_w[0]) < dam_sext(thr_reg[0][13:0])
      ##1 ch_on[0] |-> alarm_reg[0])
    else $error("alarm 1 less-than missed");
  AST_DISABLED2: assert property (!ch_on[1] |=> !alarm_reg[1])
    else $error("disabled alarm 2 raised");
  AST_HOLD0: assert property (!i_sample_valid && ch_on[0] && !slope_compare_enable[0]
      |=> alarm_reg[0] == $past(alarm_reg[0]))
    else $error("alarm 1 changed without sample");
  AST_HOLD1: assert property (!i_sample_valid && ch_on[1] && !slope_compare_enable[1]
      |=> alarm_reg[1] == $past(alarm_reg[1]))
    else $error("alarm 2 changed without sample");
  AST_SLOPE_RES0: assert property (done_w[0] ##1 ch_on[0] |-> alarm_reg[0] == $past(hit_w[0]))
    else $error("alarm 1 slope result not applied");
  AST_WIN_BOUND2: assert property (nd_reg[1] < n_eff[1] || !prev_ok_reg[1])
    else $error("alarm 2 delta count exceeded window");
  AST_PRIME0: assert property (!prev_ok_reg[0] |-> !done_w[0])
    else $error("alarm 1 window closed before priming");
  AST_PRIME1: assert property (!prev_ok_reg[1] |-> !done_w[1])
    else $error("alarm 2 window closed before priming");
  AST_SLOPE_OFF0: assert property (!slope_compare_enable[0] |=> !prev_ok_reg[0])
    else $error("alarm 1 window kept in static mode");
  AST_SLOPE_OFF1: assert property (!slope_compare_enable[1] |=> !prev_ok_reg[1])
    else $error("alarm 2 window kept in static mode");
  AST_NEFF: assert property (n_eff[0] != '0 && n_eff[1] != '0)
    else $error("zero divisor in slope average");

  // ----------------------------------------
  // Pin assertions
  // ----------------------------------------
  AST_PIN_ON1: assert property (out_en && out_line && any_alm |=> !o_gp_line_one_oe_n
      && o_gp_line_one == $past(out_pol))
    else $error("line one not at asserted level");
  AST_PIN_IDLE0: assert property (out_en && !out_line && !any_alm |=> o_gp_line_zero == !$past(out_pol))
    else $error("line zero not at inactive level");
  AST_PIN_IDLE1: assert property (out_en && out_line && !any_alm |=> o_gp_line_one == !$past(out_pol))
    else $error("line one not at inactive level");
  AST_LINE_SEL: assert property (out_en |=> o_gp_line_zero_oe_n != o_gp_line_one_oe_n)
    else $error("not exactly one line driven");
  AST_PIN_LOW: assert property (!out_en |=> !o_gp_line_zero && !o_gp_line_one)
    else $error("pin level not low while disabled");
  AST_UNSEL0: assert property (out_line |=> o_gp_line_zero_oe_n && !o_gp_line_zero)
    else $error("line zero driven while line one chosen");

  COV_STATIC: cover property (i_sample_valid && !slope_compare_enable[0] ##1 alarm_reg[0]);
  COV_SLOPE: cover property (done_w[1] && hit_w[1] ##1 alarm_reg[1]);
  COV_CLEAR: cover property (status_reg[0] && rd_stat ##1 status_reg == '0);
  COV_PIN: cover property (out_en && out_line && any_alm ##1 !o_gp_line_one_oe_n);
  COV_STAT_RD: cover property (rd_stat && status_reg[1] ##1 o_reg_rdata[dam_pkg::STAT_ALM2_BIT]);

endmodule

`default_nettype wire

// ===== testbench/dam_host_model.sv
// Host model issuing register writes and reads to the alarm monitor
`timescale 1ns/1ps
`default_nettype none

module dam_host_model (
  input  wire logic                  i_ref_clk,
  output var  dam_pkg::dam_reg_req_t o_reg_req,
  input  wire logic [15:0]           i_reg_rdata
);
  // ----------------------------------------
  // Idle bus drops wr and rd and shows inverted last address and data
  // ----------------------------------------
  initial o_reg_req = '0;

  task automatic release_bus();
    o_reg_req.wr    = 1'b0;
    o_reg_req.rd    = 1'b0;
    o_reg_req.addr  = ~o_reg_req.addr;
    o_reg_req.wdata = ~o_reg_req.wdata;
  endtask

  // Called one step after a rising edge; returns the same way
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    o_reg_req.addr  = a;
    o_reg_req.wdata = d;
    o_reg_req.wr    = 1'b1;
    @(posedge i_ref_clk);
    #1 release_bus();
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    o_reg_req.addr = a;
    o_reg_req.rd   = 1'b1;
    @(posedge i_ref_clk);
    #1 release_bus();
    @(posedge i_ref_clk);
    #1 d = i_reg_rdata;
  endtask
endmodule

`default_nettype wire

// ===== testbench/dual_alarm_event_monitor_tb.sv
// Self-checking bench for the dual alarm event monitor
`timescale 1ns/1ps
`default_nettype none

module dual_alarm_event_monitor_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                  clk;
  logic                  rst;
  dam_pkg::dam_reg_req_t req;
  logic [15:0]           rdata;
  logic                  valid;
  dam_pkg::dam_src_t     raw;
  dam_pkg::dam_src_t     filt;
  logic [1:0]            alarm;
  logic                  l0;
  logic                  l0_oe_n;
  logic                  l1;
  logic                  l1_oe_n;
  int                    n_errors;
  int                    comparisons;
  int                    cycles;
  logic [15:0]           rv;

  dam_alarm_monitor dut (
    .i_ref_clk(clk), .i_reset(rst), .i_reg_req(req), .o_reg_rdata(rdata),
    .i_sample_valid(valid), .i_src_raw(raw), .i_src_filt(filt),
    .o_alarm_active(alarm), .o_gp_line_zero(l0), .o_gp_line_zero_oe_n(l0_oe_n),
    .o_gp_line_one(l1), .o_gp_line_one_oe_n(l1_oe_n)
  );

  dam_host_model host (.i_ref_clk(clk), .o_reg_req(req), .i_reg_rdata(rdata));

  // ----------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic sample(input int k, input logic [13:0] r, input logic [13:0] f);
    raw     = '0;
    filt    = '0;
    raw[k]  = r;
    filt[k] = f;
    valid   = 1'b1;
    tick(1);
    valid = 1'b0;
    tick(2);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [6:0]  offs [5];
    logic [15:0] msk [5];
    offs = '{dam_pkg::OFF_THR1, dam_pkg::OFF_THR2, dam_pkg::OFF_CNT1, dam_pkg::OFF_CNT2, dam_pkg::OFF_CTRL};
    msk  = '{16'hBFFF, 16'hBFFF, 16'h00FF, 16'h00FF, 16'hFFD7};
    for (int i = 0; i < 5; i++) begin
      host.rd(offs[i], rv);
      check(rv, 16'h0000);
      host.wr(offs[i], 16'hFFFF);
      host.rd(offs[i], rv);
      check(rv, msk[i]);
      host.wr(offs[i], 16'h0000);
    end
    host.wr(7'h30, 16'hFFFF);
    host.rd(7'h30, rv);
    check(rv, 16'h0000);
    host.wr(dam_pkg::OFF_STATUS, 16'hFFFF);
    host.rd(dam_pkg::OFF_STATUS, rv);
    check(rv, 16'h0000);
    $display("t_regs done");
  endtask

  task automatic t_sources();
    host.wr(dam_pkg::OFF_THR2, 16'h8064);
    host.wr(dam_pkg::OFF_THR1, 16'h0064);
    for (int k = 1; k < 12; k++) begin
      host.wr(dam_pkg::OFF_CTRL, {k[3:0], k[3:0], 8'h00});
      sample(k - 1, 14'h00C8, 14'h0000);
      check(alarm, 2'b10);
      sample(k - 1, 14'h0032, 14'h0000);
      check(alarm, 2'b01);
    end
    host.wr(dam_pkg::OFF_CTRL, 16'h0000);
    sample(0, 14'h0032, 14'h0032);
    check(alarm, 2'b00);
    $display("t_sources done");
  endtask

  task automatic t_filter();
    host.wr(dam_pkg::OFF_THR1, 16'h8005);
    host.wr(dam_pkg::OFF_CTRL, 16'h0110);
    sample(0, 14'h0000, 14'h0009);
    check(alarm, 2'b01);
    host.wr(dam_pkg::OFF_CTRL, 16'h0100);
    sample(0, 14'h0000, 14'h0009);
    check(alarm, 2'b00);
    $display("t_filter done");
  endtask

  task automatic t_slope();
    logic [13:0] v [10];
    logic [1:0]  e [10];
    v = '{0, 6, 12, 18, 24, 29, 34, 39, 44, 44};
    e = '{0, 0, 0, 0, 1, 1, 1, 1, 0, 0};
    host.wr(dam_pkg::OFF_CTRL, 16'h0000);
    host.wr(dam_pkg::OFF_CNT1, 16'h0004);
    host.wr(dam_pkg::OFF_THR1, 16'h8005);
    host.wr(dam_pkg::OFF_CTRL, 16'h0140);
    for (int i = 0; i < 9; i++) begin
      sample(0, v[i], v[i]);
      check(alarm, e[i]);
    end
    host.wr(dam_pkg::OFF_CTRL, 16'h0000);
    host.wr(dam_pkg::OFF_CNT2, 16'h0002);
    host.wr(dam_pkg::OFF_THR2, 16'h8003);
    host.wr(dam_pkg::OFF_CTRL, 16'h1080);
    sample(0, 14'h0000, 14'h0000);
    check(alarm, 2'b00);
    sample(0, 14'h0004, 14'h0004);
    check(alarm, 2'b00);
    sample(0, 14'h0008, 14'h0008);
    check(alarm, 2'b10);
    $display("t_slope done");
  endtask

  task automatic t_status();
    host.rd(dam_pkg::OFF_STATUS, rv);
    host.wr(dam_pkg::OFF_THR2, 16'h8005);
    host.wr(dam_pkg::OFF_CTRL, 16'h2200);
    sample(1, 14'h0009, 14'h0009);
    check(alarm, 2'b11);
    sample(1, 14'h0000, 14'h0000);
    check(alarm, 2'b00);
    host.rd(dam_pkg::OFF_STATUS, rv);
    check(rv, 16'h0300);
    host.rd(dam_pkg::OFF_STATUS, rv);
    check(rv, 16'h0000);
    $display("t_status done");
  endtask

  task automatic t_pin();
    logic pol;
    logic line;
    host.wr(dam_pkg::OFF_THR1, 16'h8005);
    for (int i = 0; i < 4; i++) begin
      pol  = i[1];
      line = i[0];
      host.wr(dam_pkg::OFF_CTRL, 16'h0104 | i[15:0]);
      sample(0, 14'h0009, 14'h0009);
      check({l1_oe_n, l0_oe_n, l1, l0}, {line ? 2'b01 : 2'b10, line ? {pol, 1'b0} : {1'b0, pol}});
      sample(0, 14'h0000, 14'h0000);
      check({l1_oe_n, l0_oe_n, l1, l0}, {line ? 2'b01 : 2'b10, line ? {~pol, 1'b0} : {1'b0, ~pol}});
    end
    host.wr(dam_pkg::OFF_CTRL, 16'h0102);
    sample(0, 14'h0009, 14'h0009);
    check({l1_oe_n, l0_oe_n, l1, l0}, 16'h000C);
    $display("t_pin done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n_errors    = 0;
    comparisons = 0;
    cycles      = 0;
    rst         = 1'b1;
    valid       = 1'b0;
    raw         = '0;
    filt        = '0;
    tick(6);
    rst = 1'b0;
    tick(1);
    t_regs();
    t_sources();
    t_filter();
    t_slope();
    t_status();
    t_pin();
    print_verdict();
  end
endmodule

`default_nettype wire
